// [verilog/srrb_pkg.sv]
/*
  Constants and carrier types of the serial register readback block.
  Assumes a host that drives the serial clock, data and load strobe of a
  three-wire programming port, and a system reference clock beside it.
*/
package srrb_pkg;

  // ************************************************************
  // Word layout.
  // ************************************************************
  localparam int              WORD_W   = 32;
  localparam int              ADDR_W   = 4;
  localparam int              DATA_W   = 28;
  localparam int              NUM_REGS = 16;
  localparam logic [5:0]      IDX_DONE = 6'h20;
  localparam logic [3:0]      ADDR_ONES = 4'hF;

  // ************************************************************
  // Register addresses, field positions and reset values.
  // ************************************************************
  localparam logic [3:0]      ADDR_IDENT_REG  = 4'h0;
  localparam logic [3:0]      ADDR_PINSEL_REG = 4'h5;
  localparam logic [3:0]      ADDR_DIAG_REG   = 4'h6;
  localparam int              ID_SEL_BIT      = 27;
  localparam int              RD_SEL_LSB      = 1;
  localparam int              RD_SEL_W        = 4;
  localparam int              STATUS_SEL_LSB  = 0;
  localparam int              LOCK_SEL_LSB    = 5;
  localparam int              SEL_W           = 5;
  localparam logic [4:0]      SEL_READBACK    = 5'h0C;
  localparam logic [DATA_W-1:0] REG_RESET     = 28'h0000000;

  // Identity word; the base value is arbitrary, straps fill bits 5:4.
  localparam logic [WORD_W-1:0] PART_ID_BASE  = 32'h00000A00;
  localparam int              ID_STRAP_LSB    = 4;

  // ************************************************************
  // Carrier types.
  // ************************************************************
  typedef struct packed {
    logic                     id_sel;
    logic [RD_SEL_W-1:0]      rd_sel;
    logic [SEL_W-1:0]         status_sel;
    logic [SEL_W-1:0]         lock_sel;
  } srrb_cfg_t;

  typedef struct packed {
    logic [WORD_W-1:0]        shift;
    logic [5:0]               idx;
    logic                     seen;
  } srrb_link_t;

  typedef struct packed {
    logic                     tgl_seen;
    logic                     upd;
    srrb_cfg_t                cfg;
  } srrb_ref_t;

endpackage : srrb_pkg

// [verilog/srrb_sync.sv]
/*
  Two flip-flop synchroniser for level signals of a given width.
  Assumes each bit is a level that stays put for several destination clocks.
*/
module srrb_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : srrb_sync

// [verilog/srrb_top.sv]
/*
  Serial programming port with register readback.
  Holds the input shift register and readback sequencer on the serial clock,
  the register bank on the load strobe edge, and the configuration copy on
  the reference clock. Assumes the host changes data and load strobe only
  while the serial clock is low, as the port requires.
*/
module srrb_top (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              serial_clk,
  input  wire logic              serial_data,
  input  wire logic              load_strobe,
  input  wire logic [1:0]        id_strap_pins,
  input  wire logic              status_func_in,
  input  wire logic              lock_func_in,
  output logic                   status_output_pin,
  output logic                   lock_indicator_pin,
  output srrb_pkg::srrb_cfg_t    cfg,
  output logic                   cfg_update
);

  // ************************************************************
  // Declarations.
  // ************************************************************
  srrb_pkg::srrb_link_t                  link_r;
  srrb_pkg::srrb_link_t                  link_nxt;
  srrb_pkg::srrb_ref_t                   ref_r;
  srrb_pkg::srrb_ref_t                   ref_nxt;
  logic                                  load_tgl_r;
  logic [srrb_pkg::DATA_W-1:0]           regs_r [srrb_pkg::NUM_REGS];
  logic                                  tgl_sync;
  logic [1:0]                            strap_sync;
  srrb_pkg::srrb_cfg_t                   cfg_live;
  logic [srrb_pkg::WORD_W-1:0]           rb_word;
  logic [5:0]                            rb_idx;
  logic                                  rb_bit;

  // Decodes the configuration fields out of the register bank.
  function automatic srrb_pkg::srrb_cfg_t decode_cfg(
    input logic [srrb_pkg::DATA_W-1:0] r_ident,
    input logic [srrb_pkg::DATA_W-1:0] r_pinsel,
    input logic [srrb_pkg::DATA_W-1:0] r_diag
  );
    srrb_pkg::srrb_cfg_t c;
    c.id_sel     = r_ident[srrb_pkg::ID_SEL_BIT];
    c.rd_sel     = r_diag[srrb_pkg::RD_SEL_LSB +: srrb_pkg::RD_SEL_W];
    c.status_sel = r_pinsel[srrb_pkg::STATUS_SEL_LSB +: srrb_pkg::SEL_W];
    c.lock_sel   = r_pinsel[srrb_pkg::LOCK_SEL_LSB +: srrb_pkg::SEL_W];
    return c;
  endfunction : decode_cfg

  // ************************************************************
  // Load strobe edge: register bank and start event.
  // ************************************************************

  // The rising strobe moves the data field into the addressed register
  // and toggles the start flag for the readback sequencer.
  always_ff @(posedge load_strobe or negedge rst_n)
  begin
    if (!rst_n)
    begin
      load_tgl_r <= 1'b0;
      for (int i = 0; i < srrb_pkg::NUM_REGS; i++)
      begin
        regs_r[i] <= srrb_pkg::REG_RESET;
      end
    end
    else
    begin
      load_tgl_r <= ~load_tgl_r;
      regs_r[link_r.shift[srrb_pkg::ADDR_W-1:0]] <=
        link_r.shift[srrb_pkg::WORD_W-1:srrb_pkg::ADDR_W];
    end
  end

  // Live configuration drives the pin muxes without waiting for a clock.
  assign cfg_live = decode_cfg(regs_r[srrb_pkg::ADDR_IDENT_REG],
                               regs_r[srrb_pkg::ADDR_PINSEL_REG],
                               regs_r[srrb_pkg::ADDR_DIAG_REG]);

  // ************************************************************
  // Readback word and bit selection.
  // ************************************************************

  // The word is taken from the bank as it stands, so a load that rewrites
  // the select registers changes the readback word at that same strobe edge.
  // Identity or selected register, address positions forced to ones.
  always_comb
  begin
    rb_word = '0;
    if (cfg_live.id_sel)
    begin
      rb_word = srrb_pkg::PART_ID_BASE |
                {{(srrb_pkg::WORD_W - srrb_pkg::ID_STRAP_LSB - 2){1'b0}}, strap_sync,
                 {srrb_pkg::ID_STRAP_LSB{1'b0}}};
    end
    else
    begin
      rb_word[srrb_pkg::WORD_W-1:srrb_pkg::ADDR_W] = regs_r[cfg_live.rd_sel];
    end
    rb_word[srrb_pkg::ADDR_W-1:0] = srrb_pkg::ADDR_ONES;
  end

  // A pending start shows index zero at once, so bit 31 is out before any clock.
  assign rb_idx = (load_tgl_r != link_r.seen) ? 6'h00 : link_r.idx;

  // Bits go out MSB first; past the last bit the pin reads low.
  assign rb_bit = (rb_idx < srrb_pkg::IDX_DONE) ?
                  rb_word[5'h1F - rb_idx[4:0]] : 1'b0;

  // Readback replaces the pin's normal function when selected.
  assign status_output_pin  = (cfg_live.status_sel == srrb_pkg::SEL_READBACK) ?
                              rb_bit : status_func_in;
  assign lock_indicator_pin = (cfg_live.lock_sel == srrb_pkg::SEL_READBACK) ?
                              rb_bit : lock_func_in;

  // ************************************************************
  // Serial clock domain: input shift and readback index.
  // ************************************************************

  // The start flag is read here without a synchroniser: the host keeps the
  // serial clock low for half a period around every strobe rise.
  // Shifts input only while the strobe is low and steps the readback index.
  always_comb
  begin
    link_nxt = link_r;
    if (!load_strobe)
    begin
      link_nxt.shift = {link_r.shift[srrb_pkg::WORD_W-2:0], serial_data};
    end
    link_nxt.seen = load_tgl_r;
    if (rb_idx != srrb_pkg::IDX_DONE)
    begin
      link_nxt.idx = rb_idx + 6'h01;
    end
    else
    begin
      link_nxt.idx = srrb_pkg::IDX_DONE;
    end
  end

  // Registers the serial clock domain state.
  always_ff @(posedge serial_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link_r <= '{shift: '0, idx: srrb_pkg::IDX_DONE, seen: 1'b0};
    end
    else
    begin
      link_r <= link_nxt;
    end
  end

  // ************************************************************
  // Reference clock domain: configuration copy.
  // ************************************************************

  // Brings the write toggle and the identity straps onto the reference clock.
  srrb_sync #(.W(1)) u_sync_tgl (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .d     (load_tgl_r),
    .q     (tgl_sync)
  );

  // The straps are static, so their synchronised copy may feed the pin logic.
  srrb_sync #(.W(2)) u_sync_strap (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .d     (id_strap_pins),
    .q     (strap_sync)
  );

  // A toggle change means the bank settled two clocks ago; copy it then.
  always_comb
  begin
    ref_nxt          = ref_r;
    ref_nxt.upd      = 1'b0;
    ref_nxt.tgl_seen = tgl_sync;
    if (tgl_sync != ref_r.tgl_seen)
    begin
      ref_nxt.upd = 1'b1;
      ref_nxt.cfg = cfg_live;
    end
  end

  // Registers the reference clock domain state.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_r <= '0;
    end
    else
    begin
      ref_r <= ref_nxt;
    end
  end

  // The configuration copy and its update pulse leave straight from flip-flops.
  assign cfg        = ref_r.cfg;
  assign cfg_update = ref_r.upd;

endmodule : srrb_top

// [sim/srrb_props.sv]
/*
  Port checker of the serial readback block.
  Assumes it is bound to srrb_top and sees only its ports.
*/
module srrb_props (
  input wire logic                ref_clk,
  input wire logic                rst_n,
  input wire logic                serial_clk,
  input wire logic                serial_data,
  input wire logic                load_strobe,
  input wire logic [1:0]          id_strap_pins,
  input wire logic                status_func_in,
  input wire logic                lock_func_in,
  input wire logic                status_output_pin,
  input wire logic                lock_indicator_pin,
  input wire srrb_pkg::srrb_cfg_t cfg,
  input wire logic                cfg_update
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] quiet_r;
  logic       ls_r;
  logic       quiet;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Counts reference cycles since the strobe last rose.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      quiet_r <= 4'h0;
      ls_r <= 1'b0;
    end
    else
    begin
      ls_r <= load_strobe;
      quiet_r <= (load_strobe && !ls_r) ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'h8};
    end
  end
  // Settled once the configuration copy has caught up with the last load.
  always_comb quiet = quiet_r == 4'h8 && !(load_strobe && !ls_r);
  // The pins keep their normal functions while readback is not selected.
  status_mux_a: assert property (quiet && cfg.status_sel != srrb_pkg::SEL_READBACK
    |-> status_output_pin == status_func_in)
    else $error("status pin lost its normal function");
  lock_mux_a: assert property (quiet && cfg.lock_sel != srrb_pkg::SEL_READBACK
    |-> lock_indicator_pin == lock_func_in)
    else $error("lock pin lost its normal function");
  // A readback bit moves only at a serial clock rise or a strobe rise.
  status_step_a: assert property (quiet_r == 4'h8 && cfg.status_sel == srrb_pkg::SEL_READBACK
    && $changed(status_output_pin) |-> $rose(serial_clk) || $rose(load_strobe))
    else $error("status readback bit moved without a clock rise");
  lock_step_a: assert property (quiet_r == 4'h8 && cfg.lock_sel == srrb_pkg::SEL_READBACK
    && $changed(lock_indicator_pin) |-> $rose(serial_clk) || $rose(load_strobe))
    else $error("lock readback bit moved without a clock rise");
  upd_pulse_a: assert property (cfg_update |=> !cfg_update)
    else $error("update pulse longer than one cycle");
  cfg_cause_a: assert property (!$stable(cfg) |-> cfg_update)
    else $error("configuration changed without an update pulse");
  upd_follows_a: assert property ($rose(load_strobe) |-> ##[1:8] cfg_update)
    else $error("load not followed by an update pulse");
  upd_cause_a: assert property (cfg_update |-> quiet_r != 4'h8)
    else $error("update pulse without a recent load");
  cover property (cfg_update);
  cover property (cfg.status_sel == srrb_pkg::SEL_READBACK && $rose(serial_clk));
  cover property (cfg.lock_sel == srrb_pkg::SEL_READBACK && $rose(serial_clk));
endmodule : srrb_props
bind srrb_top srrb_props u_props (.ref_clk, .rst_n, .serial_clk, .serial_data, .load_strobe,
  .id_strap_pins, .status_func_in, .lock_func_in, .status_output_pin, .lock_indicator_pin,
  .cfg, .cfg_update);

// [sim/srrb_host.sv]
/*
  Host controller model of the three-wire port.
  Assumes the bench calls xfer once a frame; the clock stands low between frames.
*/
module srrb_host (
  output logic      serial_clk,
  output logic      serial_data,
  output logic      load_strobe,
  input wire logic  status_output_pin,
  input wire logic  lock_indicator_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial serial_clk = 1'b0;
  initial serial_data = 1'b0;
  initial load_strobe = 1'b0;
  // Shifts one word in unless hold keeps the strobe high; reads bit 31 before the first rise, the rest on falling edges.
  task automatic xfer(input logic [31:0] w, input logic hold, input logic use_lock, output logic [31:0] rd);
    #80;
    if (!hold) load_strobe = 1'b0;
    rd[31] = use_lock ? lock_indicator_pin : status_output_pin;
    for (int i = 0; i < 32; i++)
    begin
      serial_data = w[31-i];
      #80 serial_clk = 1'b1;
      #80 serial_clk = 1'b0;
      if (i < 31) rd[30-i] = use_lock ? lock_indicator_pin : status_output_pin;
    end
    serial_data = ~serial_data;
    if (hold) #80 load_strobe = 1'b0;
    #80 load_strobe = 1'b1;
  endtask : xfer
endmodule : srrb_host

// [sim/srrb_top_bench.sv]
/*
  Self-checking bench of the serial readback block.
  Assumes srrb_top, srrb_host and the bound checker are compiled beside it.
*/
module srrb_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                ref_clk, rst_n, serial_clk, serial_data, load_strobe, status_func_in;
  logic                lock_func_in;
  logic                cfg_update, status_output_pin, lock_indicator_pin;
  logic [31:0]         rd;
  int                  error_cnt, cmp_count, i;
  srrb_pkg::srrb_cfg_t cfg;
  logic [31:0]         word_tbl [7] = '{32'h000018C5, 32'h000000A6, 32'h12345673, 32'h00000066,
                                        32'h000000A6, 32'h80000000, 32'h00000066};
  logic [31:0]         exp_tbl [7] = '{32'h0, 32'h0000000F, 32'h000018CF, 32'h000018CF,
                                       32'h1234567F, 32'h1234567F, srrb_pkg::PART_ID_BASE | 32'h0000002F};
  logic [6:0]          hold_m = 7'h10;
  logic [6:0]          lock_m = 7'h0C;
  srrb_top uut (.ref_clk, .rst_n, .serial_clk, .serial_data, .load_strobe, .id_strap_pins(2'h2),
    .status_func_in, .lock_func_in, .status_output_pin, .lock_indicator_pin, .cfg, .cfg_update);
  srrb_host host (.serial_clk, .serial_data, .load_strobe, .status_output_pin, .lock_indicator_pin);
  // Reference clock and normal-function inputs that toggle every one and every two cycles.
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) status_func_in <= #1 ~status_func_in;
  always @(posedge ref_clk) lock_func_in <= #1 lock_func_in ^ status_func_in;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // Before programming both pins show their normal functions.
  task automatic check_idle_pins;
    @(negedge ref_clk);
    check({31'h0, status_output_pin}, {31'h0, status_func_in});
    check({31'h0, lock_indicator_pin}, {31'h0, lock_func_in});
  endtask : check_idle_pins
  // Puts both pins in readback mode and waits for the configuration copy.
  task automatic program_pins;
    @(posedge ref_clk);
    #1 host.xfer(word_tbl[0], 1'b0, 1'b0, rd);
    for (i = 0; i < 20 && cfg_update !== 1'b1; i++) @(negedge ref_clk);
    if (i == 20)
    begin
      error_cnt++;
      final_report;
    end
    check({27'h0, cfg.status_sel}, {27'h0, srrb_pkg::SEL_READBACK});
    check({27'h0, cfg.lock_sel}, {27'h0, srrb_pkg::SEL_READBACK});
  endtask : program_pins
  // Back-to-back frames: register, both pins, held strobe and identity readback.
  task automatic readback_chain;
    @(posedge ref_clk);
    #1;
    for (i = 1; i < 7; i++)
    begin
      host.xfer(word_tbl[i], hold_m[i], lock_m[i], rd);
      check(rd, exp_tbl[i]);
    end
  endtask : readback_chain
  initial
  begin
    error_cnt = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    status_func_in = 1'b0;
    lock_func_in = 1'b0;
    repeat (10) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    check_idle_pins;
    program_pins;
    readback_chain;
    final_report;
  end
endmodule : srrb_top_bench
